// >>> rtl/ssa_pkg.sv
// Purpose: Shared constants and types of the sensor two-wire slave with alert.
// Assumes: A 40 MHz core clock.
// Notes: Register pointer codes, reset values and field positions live here.
package ssa_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;  // Core clock rate in hertz.
  localparam int TIMEOUT_MS = 35;  // Stuck-low bus timeout in milliseconds.
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;  // Timeout in cycles.

  // ----------------------------------------------------------------------
  // Register pointers and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] PTR_TEMP = 2'h0;  // Measured value, read only.
  localparam logic [1:0] PTR_CFG = 2'h1;  // Configuration word.
  localparam logic [1:0] PTR_TLOW = 2'h2;  // Low limit.
  localparam logic [1:0] PTR_THIGH = 2'h3;  // High limit.
  localparam logic [7:0] PTR_MAX = 8'h03;  // Highest legal pointer byte.
  localparam logic [15:0] CFG_RST = 16'h0000;  // Configuration after reset.
  localparam logic [15:0] TLOW_RST = 16'h4b00;  // Low limit after reset.
  localparam logic [15:0] THIGH_RST = 16'h5000;  // High limit after reset.
  localparam logic [15:0] TEMP_RST = 16'h0000;  // Measured value after reset.

  // ----------------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------------
  localparam int CFG_SD_BIT = 8;  // Shutdown control.
  localparam int CFG_ALERT_MODE_SELECT_BIT = 9;  // Alert mode select, 1 is interrupt mode.
  localparam int CFG_POL_BIT = 10;  // Alert polarity, 1 is active high.
  localparam int CFG_FQLO_BIT = 11;  // Fault queue, low bit.
  localparam int CFG_FQHI_BIT = 12;  // Fault queue, high bit.
  localparam int CFG_AL_BIT = 13;  // Alert status, read only.
  localparam logic [2:0] FQ_N0 = 3'h1;  // Fault counts per queue code.
  localparam logic [2:0] FQ_N1 = 3'h2;
  localparam logic [2:0] FQ_N2 = 3'h4;
  localparam logic [2:0] FQ_N3 = 3'h6;

  // ----------------------------------------------------------------------
  // Bus addresses and codes
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_GCALL = 7'h00;  // General call.
  localparam logic [6:0] ADDR_ARA = 7'h0c;  // Alert response address.
  localparam logic [7:0] GC_RESET = 8'h06;  // General-call reset command.
  localparam logic [4:0] HS_PREFIX = 5'h01;  // High-speed master code, top bits.
  localparam logic [6:0] ADDR_BASE_PP = 7'h48;  // Both low straps at a rail.
  localparam logic [6:0] ADDR_BASE_PD = 7'h40;  // Strap 0 on a bus line.
  localparam logic [6:0] ADDR_BASE_DD = 7'h50;  // Straps 1 and 0 on bus lines.
  localparam logic [6:0] ADDR_BASE_DP = 7'h58;  // Strap 1 on a bus line.

  // ----------------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_GCALL, ST_TX, ST_SKIP
  } ssa_state_type;
endpackage

// >>> rtl/ssa_smbus_slave_alert.sv
// Purpose: Two-wire slave, register file and alert pin of a temperature sensor.
// Assumes: Bus lines are open drain; measured values come with a strobe.
// Notes: SCL clocks the bit sampler; protocol runs on the core clock.
// Behaviour
// RULE_01: Stuck-low line beyond timeout returns to idle.
// RULE_02: Write is address, pointer byte, then data.
// RULE_03: Read uses pointer write, repeated start, read.
// RULE_04: Each register holds one sixteen-bit word.
// RULE_05: Single-byte access transfers the upper byte.
// RULE_06: Works at standard and fast bus rates.
// RULE_07: SMBus host keeps clock above its minimum.
// RULE_08: Timeout only active in SMBus behaviour.
// RULE_09: Alert response answered only in SMBus behaviour.
// RULE_10: Acknowledge general call and its command byte.
// RULE_11: General-call reset command restores all defaults.
// RULE_12: Host sends master code before high speed.
// RULE_13: High speed holds until stop, then reverts.
// RULE_14: Alert pin open drain, polarity bit selects level.
// RULE_15: Comparator mode: high faults set, below low clears.
// RULE_16: Interrupt mode: set by faults, cleared by read.
// RULE_17: After clear, reassert only below low limit.
// RULE_18: Shutdown clears asserted alert in interrupt mode.
// RULE_19: Alert response works only in interrupt mode.
// RULE_20: Alerting device acknowledges and returns own address.
// RULE_21: Lowest address wins; only winner releases alert.
// RULE_22: Returned address low bit gives alert source.
// RULE_23: Three straps decode into thirty-two addresses.
// RULE_24: Fault queue needs 1, 2, 4 or 6.
// RULE_25: Compare value against limits each conversion.
// RULE_26: Polarity resets to zero, alert active low.
// RULE_27: Static input selects SMBus or plain behaviour.
// RULE_28: Pointer-only write sets pointer; reads reuse it.
`timescale 1ns/1ps
`default_nettype none
module ssa_smbus_slave_alert
  import ssa_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC  // Stuck-low limit in core cycles.
) (
  // Core clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Bus clock line, also the link clock.
  input wire logic scl_clk_in,
  // Bus data line, open drain.
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  // Alert pin, open drain.
  output logic alert_out,
  output logic alert_oe_b_out,
  // Address straps: 0 ground, 1 supply, 2 data line, 3 clock line.
  input wire logic [1:0] addr_strap_2_in,
  input wire logic [1:0] addr_strap_1_in,
  input wire logic [1:0] addr_strap_0_in,
  // Behaviour select, 1 is SMBus, 0 is plain two-wire.
  input wire logic smbus_mode_in,
  // Conversion results from the converter.
  input wire logic [15:0] temp_in,
  input wire logic conv_done_in,
  // Status towards the rest of the chip.
  output logic shutdown_out,
  output logic hs_mode_out
);
  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);  // Timeout counter width.
  localparam logic [TW-1:0] TO_LIM = TW'(TIMEOUT_CYCLES);  // Counter limit.

  // Link-domain state, clocked by the bus clock.
  typedef struct packed {
    logic [7:0] shift;  // Last eight sampled data bits.
    logic tgl;  // Flips on every bus clock rise.
  } ssa_link_type;

  // Core-domain state.
  typedef struct packed {
    ssa_state_type st;  // Protocol state.
    logic scl_m, scl_s, scl_d;  // Clock line synchroniser and delay.
    logic sda_m, sda_s, sda_d;  // Data line synchroniser and delay.
    logic tgl_m, tgl_s, tgl_d;  // Rise toggle synchroniser and delay.
    logic [5:0] strap_m, strap_s;  // Strap synchroniser.
    logic [3:0] bitcnt;  // Rises since start or since the last ninth bit.
    logic ack_want;  // This device acknowledges the current byte.
    logic drive;  // Data line pulled low.
    logic byte_idx;  // Byte of the word in transfer, 0 is the upper.
    logic is_ara;  // Current transmit is an alert response.
    logic hs;  // High-speed operation.
    logic [7:0] txbyte;  // Byte being shifted out.
    logic [1:0] ptr;  // Register pointer.
    logic [15:0] cfg, tlow, thigh, temp;  // Register file.
    logic cond;  // Comparator condition, 1 after high faults.
    logic alert;  // Interrupt-mode alert latch.
    logic src;  // Alert source, 1 for high limit.
    logic [2:0] fcnt;  // Consecutive fault count.
    logic [TW-1:0] tocnt;  // Stuck-low counter.
    logic alert_oe_b;  // Registered alert enable.
  } ssa_core_type;

  ssa_link_type lk;
  ssa_link_type next_lk;
  ssa_core_type q;
  ssa_core_type next_q;

  // Refuse a timeout too short for the counter to mean anything.
  if (TIMEOUT_CYCLES < 2) begin : g_chk
    $error("TIMEOUT_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------------
  // Link domain: bit sampler
  // ----------------------------------------------------------------------
  // Data is sampled on the bus clock itself, so no sampling rate limits data
  // capture; the core still follows each clock rise and fall to count bits and drive data.
  always_comb begin
    next_lk = lk;
    next_lk.shift = {lk.shift[6:0], sda_in};  // RULE_06
    next_lk.tgl = ~lk.tgl;
  end

  // The link register only updates on bus clock rises.
  always_ff @(posedge scl_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------------
  // Core events and decodes
  // ----------------------------------------------------------------------
  logic rise_ev;  // A bus clock rise has been sampled.
  logic fall_ev;  // Synchronised clock line fell.
  logic start_ev;  // Start or repeated start.
  logic stop_ev;  // Stop condition.
  logic byte_ev;  // Eighth bit of a byte sampled.
  logic to_hit;  // Stuck-low limit reached.
  logic [7:0] rx_byte;  // Received byte, stable while the core reads it.
  logic [6:0] own_addr;  // Decoded slave address.
  logic [6:0] addr_base;  // Address group chosen by strap kinds.
  logic [15:0] rd_word;  // Word at the pointer.
  logic mode_int;  // Interrupt mode selected.
  logic polarity;  // Alert polarity.
  logic shut;  // Shutdown selected.
  logic alert_act;  // Alert is logically active.
  logic ara_ok;  // Alert response may be answered.
  logic [2:0] fq_n;  // Faults needed.
  logic hi_now, lo_now, conv_ev;  // Comparison results.

  assign rise_ev = q.tgl_s ^ q.tgl_d;
  assign fall_ev = q.scl_d & ~q.scl_s;
  assign start_ev = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
  assign stop_ev = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;
  assign byte_ev = rise_ev && (q.bitcnt == 4'h7);
  assign to_hit = smbus_mode_in && (q.tocnt == TO_LIM);  // RULE_08
  assign rx_byte = lk.shift;
  assign mode_int = q.cfg[CFG_ALERT_MODE_SELECT_BIT];
  assign polarity = q.cfg[CFG_POL_BIT];
  assign shut = q.cfg[CFG_SD_BIT];
  assign alert_act = mode_int ? q.alert : q.cond;
  assign ara_ok = smbus_mode_in && mode_int && q.alert;  // RULE_09 RULE_19
  assign conv_ev = conv_done_in && !shut;
  assign hi_now = $signed(temp_in) >= $signed(q.thigh);  // RULE_25
  assign lo_now = $signed(temp_in) < $signed(q.tlow);  // RULE_25

  // Strap bit 1 marks a bus-line strap, bit 0 the supply or clock line.
  assign addr_base = q.strap_s[3] ? (q.strap_s[1] ? ADDR_BASE_DD : ADDR_BASE_DP)
                                  : (q.strap_s[1] ? ADDR_BASE_PD : ADDR_BASE_PP);
  assign own_addr = addr_base | {4'h0, q.strap_s[4], q.strap_s[2], q.strap_s[0]};  // RULE_23

  // Fault queue code to count.
  always_comb begin
    unique case ({q.cfg[CFG_FQHI_BIT], q.cfg[CFG_FQLO_BIT]})  // RULE_24
      2'h0: fq_n = FQ_N0;
      2'h1: fq_n = FQ_N1;
      2'h2: fq_n = FQ_N2;
      2'h3: fq_n = FQ_N3;
    endcase
  end

  // Read mux; the status bit reads as the inverted polarity when idle.
  always_comb begin
    unique case (q.ptr)
      PTR_TEMP: rd_word = q.temp;
      PTR_CFG: begin
        rd_word = q.cfg;
        rd_word[CFG_AL_BIT] = alert_act ? polarity : ~polarity;
      end
      PTR_TLOW: rd_word = q.tlow;
      PTR_THIGH: rd_word = q.thigh;
    endcase
  end

  // ----------------------------------------------------------------------
  // Core next state
  // ----------------------------------------------------------------------
  logic clr_rd, ara_win, ev_set, ev_src, gc_rst;
  always_comb begin
    next_q = q;
    clr_rd = 1'b0;
    ara_win = 1'b0;
    ev_set = 1'b0;
    ev_src = 1'b0;
    gc_rst = 1'b0;
    // Synchronisers; first stages feed only second stages.
    next_q.scl_m = scl_clk_in;
    next_q.scl_s = q.scl_m;
    next_q.scl_d = q.scl_s;
    next_q.sda_m = sda_in;
    next_q.sda_s = q.sda_m;
    next_q.sda_d = q.sda_s;
    next_q.tgl_m = lk.tgl;
    next_q.tgl_s = q.tgl_m;
    next_q.tgl_d = q.tgl_s;
    next_q.strap_m = {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
    next_q.strap_s = q.strap_m;

    // Stuck-low counter, held at zero in plain two-wire behaviour.
    if (smbus_mode_in && (!q.scl_s || !q.sda_s)) begin  // RULE_08 RULE_27
      next_q.tocnt = to_hit ? q.tocnt : q.tocnt + TW'(1);
    end else begin
      next_q.tocnt = '0;
    end

    // Byte and ninth-bit handling on each sampled rise.
    if (rise_ev) begin
      next_q.bitcnt = (q.bitcnt == 4'h8) ? 4'h0 : q.bitcnt + 4'h1;
      // A released one read back as zero means another responder won.
      if (q.st == ST_TX && q.is_ara && q.bitcnt < 4'h8 && !q.ack_want &&
          q.txbyte[3'(4'h7 - q.bitcnt)] && !rx_byte[0]) begin  // RULE_21
        next_q.st = ST_SKIP;
      end else if (byte_ev) begin
        next_q.ack_want = 1'b0;
        unique case (q.st)
          ST_ADDR: begin
            if (rx_byte[7:3] == HS_PREFIX) begin
              next_q.hs = 1'b1;  // RULE_12 RULE_13
              next_q.st = ST_SKIP;
            end else if (rx_byte[7:1] == ADDR_GCALL && !rx_byte[0]) begin
              next_q.ack_want = 1'b1;  // RULE_10
              next_q.st = ST_GCALL;
            end else if (rx_byte[7:1] == ADDR_ARA && rx_byte[0] && ara_ok) begin
              next_q.ack_want = 1'b1;  // RULE_20
              next_q.st = ST_TX;
              next_q.is_ara = 1'b1;
              next_q.txbyte = {own_addr, q.src};  // RULE_22
            end else if (rx_byte[7:1] == own_addr) begin
              next_q.ack_want = 1'b1;  // RULE_02 RULE_03
              if (rx_byte[0]) begin
                next_q.st = ST_TX;  // RULE_28
                next_q.txbyte = rd_word[15:8];  // RULE_04 RULE_05
                next_q.byte_idx = 1'b0;
                clr_rd = 1'b1;  // RULE_16
              end else begin
                next_q.st = ST_PTR;
              end
            end else begin
              next_q.st = ST_SKIP;
            end
          end
          ST_PTR: begin
            if (rx_byte <= PTR_MAX) begin
              next_q.ptr = rx_byte[1:0];  // RULE_28
              next_q.ack_want = 1'b1;
              next_q.byte_idx = 1'b0;
              next_q.st = ST_WDATA;
            end else begin
              next_q.st = ST_SKIP;
            end
          end
          ST_WDATA: begin
            // The upper byte is stored at once, so a one-byte write lands.
            next_q.ack_want = 1'b1;  // RULE_04 RULE_05
            next_q.byte_idx = 1'b1;
            unique case (q.ptr)
              PTR_CFG: begin
                if (!q.byte_idx) next_q.cfg[15:8] = rx_byte;
                else next_q.cfg[7:0] = rx_byte;
              end
              PTR_TLOW: begin
                if (!q.byte_idx) next_q.tlow[15:8] = rx_byte;
                else next_q.tlow[7:0] = rx_byte;
              end
              PTR_THIGH: begin
                if (!q.byte_idx) next_q.thigh[15:8] = rx_byte;
                else next_q.thigh[7:0] = rx_byte;
              end
              PTR_TEMP: begin
              end
            endcase
          end
          ST_GCALL: begin
            next_q.ack_want = 1'b1;  // RULE_10
            gc_rst = (rx_byte == GC_RESET);
            next_q.st = ST_SKIP;
          end
          ST_IDLE, ST_TX, ST_SKIP: begin
          end
        endcase
      end else if (q.bitcnt == 4'h8) begin
        next_q.ack_want = 1'b0;
        // Ninth bit of a sent byte: host acknowledge or end.
        if (q.st == ST_TX && !q.ack_want) begin
          if (q.is_ara) begin
            ara_win = 1'b1;  // RULE_21
            next_q.st = ST_SKIP;
          end else if (rx_byte[0]) begin
            next_q.st = ST_SKIP;  // RULE_03
          end else begin
            next_q.byte_idx = ~q.byte_idx;
            next_q.txbyte = q.byte_idx ? rd_word[15:8] : rd_word[7:0];
          end
        end
      end
    end

    // Data line changes only while the clock line is low.
    if (fall_ev) begin
      if (q.bitcnt == 4'h8) begin
        next_q.drive = q.ack_want;  // RULE_02
      end else if (q.st == ST_TX) begin
        next_q.drive = ~q.txbyte[3'(4'h7 - q.bitcnt)];
      end else begin
        next_q.drive = 1'b0;
      end
    end

    // Frame conditions override the byte logic.
    if (start_ev) begin
      next_q.st = ST_ADDR;
      next_q.bitcnt = 4'h0;
      next_q.ack_want = 1'b0;
      next_q.is_ara = 1'b0;
      next_q.drive = 1'b0;
    end
    if (stop_ev) begin
      next_q.st = ST_IDLE;
      next_q.hs = 1'b0;  // RULE_13
      next_q.drive = 1'b0;
    end
    if (to_hit) begin
      next_q.st = ST_IDLE;  // RULE_01
      next_q.bitcnt = 4'h0;
      next_q.drive = 1'b0;
    end

    // Fault queue on each conversion; the condition has hysteresis.
    if (conv_ev) begin
      next_q.temp = temp_in;
      if (!q.cond) begin
        if (hi_now) begin
          if (q.fcnt + 3'h1 >= fq_n) begin
            next_q.cond = 1'b1;  // RULE_15 RULE_24
            next_q.fcnt = 3'h0;
            ev_set = 1'b1;
            ev_src = 1'b1;
          end else begin
            next_q.fcnt = q.fcnt + 3'h1;
          end
        end else begin
          next_q.fcnt = 3'h0;
        end
      end else begin
        if (lo_now) begin
          if (q.fcnt + 3'h1 >= fq_n) begin
            next_q.cond = 1'b0;  // RULE_15 RULE_17
            next_q.fcnt = 3'h0;
            ev_set = 1'b1;
          end else begin
            next_q.fcnt = q.fcnt + 3'h1;
          end
        end else begin
          next_q.fcnt = 3'h0;
        end
      end
    end

    // Interrupt latch: a new event wins over a read, response or shutdown clear in the same cycle; a general-call reset clears it.
    if (ev_set && mode_int) begin
      next_q.alert = 1'b1;  // RULE_16 RULE_17
      next_q.src = ev_src;
    end else if (clr_rd || ara_win || (mode_int && shut)) begin
      next_q.alert = 1'b0;  // RULE_16 RULE_18
    end

    // Pin is pulled low when the active state differs from the polarity.
    next_q.alert_oe_b = ~(alert_act ^ polarity);  // RULE_14 RULE_26

    // General-call reset restores every register.
    if (gc_rst) begin
      next_q.cfg = CFG_RST;  // RULE_11
      next_q.tlow = TLOW_RST;
      next_q.thigh = THIGH_RST;
      next_q.temp = TEMP_RST;
      next_q.ptr = PTR_TEMP;
      next_q.cond = 1'b0;
      next_q.alert = 1'b0;
      next_q.src = 1'b0;
      next_q.fcnt = 3'h0;
    end
  end

  // Core register, reset to constants only.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.tlow <= TLOW_RST;
      q.thigh <= THIGH_RST;
      q.alert_oe_b <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe_b_out = ~q.drive;
  assign alert_out = 1'b0;
  assign alert_oe_b_out = q.alert_oe_b;
  assign shutdown_out = q.cfg[CFG_SD_BIT];
  assign hs_mode_out = q.hs;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_gc_reset_byte;
    byte_ev && q.st == ST_GCALL && rx_byte == GC_RESET && !start_ev && !stop_ev;
  endsequence
  sequence s_last_hi_fault;
    conv_ev && !q.cond && hi_now && (q.fcnt + 3'h1 >= fq_n) && !gc_rst;
  endsequence

  property p_timeout;
    to_hit |=> (q.st == ST_IDLE) && !q.drive;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not idle");  // RULE_01
  property p_no_to_plain;
    !smbus_mode_in |=> q.tocnt == '0;
  endproperty
  a_no_to_plain: assert property (p_no_to_plain) else $error("timeout ran in plain mode");  // RULE_08
  property p_ara_plain;
    !smbus_mode_in |-> !(q.st == ST_TX && q.is_ara);
  endproperty
  a_ara_plain: assert property (p_ara_plain) else $error("alert response in plain mode");  // RULE_09
  property p_gc_reset;
    s_gc_reset_byte |=> q.cfg == CFG_RST && q.tlow == TLOW_RST && q.thigh == THIGH_RST;
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("general reset missed");  // RULE_11
  property p_hs_stop;
    stop_ev |=> !q.hs ##1 !q.hs || start_ev;
  endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("high speed kept after stop");  // RULE_13
  property p_pin;
    1'b1 |=> alert_oe_b_out == !($past(alert_act) ^ $past(polarity));
  endproperty
  a_pin: assert property (p_pin) else $error("alert pin level wrong");  // RULE_14
  property p_fault;
    s_last_hi_fault |=> q.cond ##1 alert_oe_b_out == !(alert_act ^ polarity);
  endproperty
  a_fault: assert property (p_fault) else $error("fault queue did not trip");  // RULE_24
  property p_shut;
    (mode_int && shut && !gc_rst) |=> !q.alert;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown left alert set");  // RULE_18
  property p_ptr;
    (byte_ev && q.st == ST_PTR && rx_byte <= PTR_MAX && !gc_rst) |=>
      q.ptr == 2'($past(rx_byte)) && q.st == ST_WDATA;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not taken");  // RULE_28
  property p_ack;
    (fall_ev && q.bitcnt == 4'h8 && q.ack_want && !start_ev && !stop_ev && !to_hit)
      |=> !sda_oe_b_out;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");  // RULE_10
endmodule
`default_nettype wire

// >>> dv/ssa_host.sv
// Purpose: Bus host model that drives the clock line and the data line.
// Assumes: Lines have pull-ups, so a released line reads high.
// Notes: Each clock phase lasts ten link ticks, a 400 kHz bus.
`timescale 1ns/1ps
`default_nettype none
module ssa_host (
  // Link tick.
  input wire logic tick_in,
  // Bus lines.
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_drv_out
);
  // --------------------------------------------------------------------
  // Bus phases
  // --------------------------------------------------------------------
  // Both lines idle high until a frame starts.
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  // One half period; never slower, so the SMBus floor holds too.
  task automatic hp();
    repeat (10) @(posedge tick_in);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_drv_out <= 1'b1;
    hp();
    scl_out <= 1'b1;
    hp();
    sda_drv_out <= 1'b0;
    hp();
    scl_out <= 1'b0;
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_drv_out <= 1'b0;
    hp();
    scl_out <= 1'b1;
    hp();
    sda_drv_out <= 1'b1;
    hp();
  endtask
  // One byte out, MSB first, then the ninth bit; a 1 releases the line.
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_drv_out <= (i == 0) ? ack_in : d[i-1];
      hp();
      scl_out <= 1'b1;
      hp();
      if (i == 0) ack = sda_in;
      else q[i-1] = sda_in;
      scl_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: Register access, general call and alert tests of the sensor slave.
// Assumes: Straps all at ground, so the own address is 0x48.
// Notes: A short timeout keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssa_pkg::*;
  logic clk_in = 1'b0;
  logic tick = 1'b0;
  logic rst_b_in = 1'b0;
  logic [15:0] temp = 16'h0000;
  logic conv = 1'b0;
  logic smb = 1'b1;
  logic [15:0] rd;
  logic [7:0] q;
  logic a;
  wire logic scl, sda_drv, oe_b, al_b, shd, sda_w, alert_w, hs;
  int n_fail = 0;
  int n_compared = 0;
  // Open-drain wires with pull-ups: low while any party pulls.
  assign sda_w = sda_drv & oe_b;
  assign alert_w = al_b;
  always #12.5 clk_in = ~clk_in;
  // Link tick, phase unrelated to the core clock.
  initial #7 forever #62.5 tick = ~tick;
  ssa_host ssa_host_i (.tick_in(tick), .sda_in(sda_w), .scl_out(scl),
    .sda_drv_out(sda_drv));
  ssa_smbus_slave_alert #(.TIMEOUT_CYCLES(4000)) ssa_smbus_slave_alert_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_clk_in(scl), .sda_in(sda_w),
    .sda_out(), .sda_oe_b_out(oe_b), .alert_out(), .alert_oe_b_out(al_b),
    .addr_strap_2_in(2'h0), .addr_strap_1_in(2'h0), .addr_strap_0_in(2'h0),
    .smbus_mode_in(smb), .temp_in(temp), .conv_done_in(conv),
    .shutdown_out(shd), .hs_mode_out(hs));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Address, pointer p, then n data bytes; pa names the expected pointer ack.
  task automatic wreg(input logic [7:0] p, input logic [15:0] d, input int n,
                      input logic pa);
    ssa_host_i.start();
    ssa_host_i.xfer(8'h90, 1'b1, q, a);
    chk(16'(a), 16'h0);
    ssa_host_i.xfer(p, 1'b1, q, a);
    chk(16'(a), 16'(pa));
    for (int i = 0; i < n; i++) ssa_host_i.xfer(d[15-8*i -: 8], 1'b1, q, a);
    ssa_host_i.stop();
  endtask
  // Word read from the current pointer, upper byte first.
  task automatic rreg(output logic [15:0] d);
    ssa_host_i.start();
    ssa_host_i.xfer(8'h91, 1'b1, q, a);
    ssa_host_i.xfer(8'hff, 1'b0, d[15:8], a);
    ssa_host_i.xfer(8'hff, 1'b1, d[7:0], a);
    ssa_host_i.stop();
  endtask
  // Address, a long clock-low hold, then a pointer byte acked as e says.
  task automatic hold(input logic e);
    ssa_host_i.start();
    ssa_host_i.xfer(8'h90, 1'b1, q, a);
    #150_000;
    ssa_host_i.xfer(8'h01, 1'b1, q, a);
    chk(16'(a), 16'(e));
    ssa_host_i.stop();
  endtask
  // One conversion result, then the alert pin against e.
  task automatic cv(input logic [15:0] t, input logic e);
    @(posedge clk_in);
    temp <= t;
    conv <= 1'b1;
    @(posedge clk_in);
    conv <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(16'(alert_w), 16'(e));
  endtask
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chk(16'({al_b, shd}), 16'h2);
    repeat (8) @(posedge clk_in);
    wreg(8'h03, 16'h0, 0, 1'b0);
    rreg(rd);
    chk(rd, THIGH_RST);
    wreg(8'h02, 16'h1234, 2, 1'b0);
    rreg(rd);
    chk(rd, 16'h1234);
    wreg(8'h02, 16'h5600, 1, 1'b0);
    rreg(rd);
    chk(rd, 16'h5634);
    wreg(8'h04, 16'h0, 0, 1'b1);
    hold(1'b1);
    $display("test registers done");
    ssa_host_i.start();
    ssa_host_i.xfer(8'h00, 1'b1, q, a);
    chk(16'(a), 16'h0);
    ssa_host_i.xfer(GC_RESET, 1'b1, q, a);
    chk(16'(a), 16'h0);
    ssa_host_i.stop();
    wreg(8'h02, 16'h0, 0, 1'b0);
    rreg(rd);
    chk(rd, TLOW_RST);
    $display("test general call done");
    cv(THIGH_RST, 1'b0);
    cv(16'h4a00, 1'b1);
    wreg(8'h01, 16'h0200, 1, 1'b0);
    cv(THIGH_RST, 1'b0);
    ssa_host_i.start();
    ssa_host_i.xfer(8'h19, 1'b1, q, a);
    chk(16'(a), 16'h0);
    ssa_host_i.xfer(8'hff, 1'b1, q, a);
    chk(16'(q), 16'({ADDR_BASE_PP, 1'b1}));
    ssa_host_i.stop();
    chk(16'(alert_w), 16'h1);
    cv(16'h4a00, 1'b0);
    $display("test alert done");
    @(posedge clk_in);
    smb <= 1'b0;
    hold(1'b0);
    ssa_host_i.start();
    ssa_host_i.xfer(8'h08, 1'b1, q, a);
    chk(16'(a), 16'h1);
    ssa_host_i.start();
    ssa_host_i.xfer(8'h19, 1'b1, q, a);
    chk(16'({a, hs}), 16'h3);
    ssa_host_i.stop();
    chk(16'(hs), 16'h0);
    rreg(rd);
    chk(rd, 16'h0200);
    chk(16'(alert_w), 16'h1);
    $display("test plain mode done");
    results();
  end
  // Watchdog: the tests need about 1.35 ms.
  initial begin
    #2_000_000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
